// file: shared/vcrt_pkg.sv
// Constants for the vertical and overflow timing part of a legacy CRT controller.
// Assumes an 8-bit I/O data port reached through the index and data ports.
`default_nettype none
package vcrt_pkg;

    // ----------------------------------------
    // Port addresses
    // ----------------------------------------
    localparam logic [15:0] IDX_PORT_MONO = 16'h03b4;
    localparam logic [15:0] DAT_PORT_MONO = 16'h03b5;
    localparam logic [15:0] IDX_PORT_COLOR = 16'h03d4;
    localparam logic [15:0] DAT_PORT_COLOR = 16'h03d5;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [6:0] IDX_HSYNC_START = 7'h04;
    localparam logic [6:0] IDX_HSYNC_END = 7'h05;
    localparam logic [6:0] IDX_VERT_TOTAL = 7'h06;
    localparam logic [6:0] IDX_VERT_OVERFLOW = 7'h07;
    localparam logic [6:0] IDX_PRESET_ROW = 7'h08;
    localparam logic [6:0] IDX_MAX_SCAN = 7'h09;
    localparam logic [6:0] IDX_START_HI = 7'h0c;
    localparam logic [6:0] IDX_START_LO = 7'h0d;
    localparam logic [6:0] IDX_VSYNC_START = 7'h10;
    localparam logic [6:0] IDX_VSYNC_END = 7'h11;
    localparam logic [6:0] IDX_VDISP_END = 7'h12;
    localparam logic [6:0] IDX_VBLANK_START = 7'h15;
    localparam logic [6:0] IDX_LINE_COMPARE = 7'h18;
    localparam logic [6:0] IDX_PROT_LAST = 7'h07;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int OVF_VT8 = 0;
    localparam int OVF_VDE8 = 1;
    localparam int OVF_VSS8 = 2;
    localparam int OVF_VBS8 = 3;
    localparam int OVF_LC8 = 4;
    localparam int OVF_VT9 = 5;
    localparam int OVF_VDE9 = 6;
    localparam int OVF_VSS9 = 7;
    localparam int MSL_VBS9 = 5;
    localparam int MSL_LC9 = 6;
    localparam int MSL_DBL = 7;
    localparam int VSE_PROTECT = 7;
    localparam logic [7:0] OVF_UNPROT_MASK = 8'h10;
    localparam logic [7:0] PRESET_RD_MASK = 8'h7f;
    localparam logic [7:0] INDEX_RD_MASK = 8'h7f;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_HSYNC_END = 8'h00;
    localparam logic [7:0] RST_VERT_TOTAL = 8'h00;
    localparam logic [7:0] RST_OVERFLOW = 8'h00;
    localparam logic [7:0] RST_PRESET = 8'h00;
    localparam logic [7:0] RST_MAX_SCAN = 8'h00;
    localparam logic [7:0] RST_OTHER = 8'h00;

    // ----------------------------------------
    // Pixels per panned byte
    // ----------------------------------------
    localparam logic [4:0] PIX_PER_BYTE_9 = 5'h09;
    localparam logic [4:0] PIX_PER_BYTE_8 = 5'h08;

endpackage

`default_nettype wire

// file: hw/vcrt_regs.sv
// Indexed register file of the vertical timing controller.
// Assumes I/O strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module vcrt_regs
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic color_emul, // Colour emulation address select
    input wire logic [15:0] io_addr, // I/O address
    input wire logic io_wr, // I/O write strobe
    input wire logic io_rd, // I/O read strobe
    input wire logic [7:0] io_wdata, // I/O write data
    output logic [7:0] io_rdata, // Read data, valid cycle after io_rd
    output logic [7:0] hsync_start_reg, // Sync start
    output logic [7:0] hsync_end_reg, // Sync end and delay
    output logic [7:0] vert_total_reg, // Vertical total low
    output logic [7:0] vert_overflow_reg, // Overflow bits
    output logic [7:0] preset_row_scan_reg, // Preset row and byte pan
    output logic [7:0] max_scan_line_reg, // Maximum scan line
    output logic [15:0] start_addr, // Start address
    output logic [7:0] vsync_start_reg, // Vertical sync start low
    output logic [7:0] vsync_end_protect_reg, // Sync end and protect
    output logic [7:0] vert_disp_end_reg, // Display end low
    output logic [7:0] vert_blank_start_reg, // Blank start low
    output logic [7:0] line_compare_reg // Line compare low
);

    typedef struct packed
    {
        logic [6:0] index;
        logic [7:0] hss, hse, vt, ovf, prs, msl, sah, sal, vss, vse, vde, vbs, lc;
        logic [7:0] rdata;
    } vcrt_regs_type;

    vcrt_regs_type r;
    vcrt_regs_type next_r;
    logic [15:0] idx_port;
    logic [15:0] dat_port;
    logic prot;

    // ----------------------------------------
    // Decode and register update
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        idx_port = color_emul ? vcrt_pkg::IDX_PORT_COLOR : vcrt_pkg::IDX_PORT_MONO;
        dat_port = color_emul ? vcrt_pkg::DAT_PORT_COLOR : vcrt_pkg::DAT_PORT_MONO;
        prot = r.vse[vcrt_pkg::VSE_PROTECT] && (r.index <= vcrt_pkg::IDX_PROT_LAST);
        if (io_wr && io_addr == idx_port)
        begin
            next_r.index = io_wdata[6:0];
        end
        if (io_wr && io_addr == dat_port)
        begin
            unique case (r.index)
                vcrt_pkg::IDX_HSYNC_START: if (!prot) next_r.hss = io_wdata;
                vcrt_pkg::IDX_HSYNC_END: if (!prot) next_r.hse = io_wdata;
                vcrt_pkg::IDX_VERT_TOTAL: if (!prot) next_r.vt = io_wdata;
                vcrt_pkg::IDX_VERT_OVERFLOW:
                begin
                    // Line compare bit 8 stays writable under protection
                    if (prot)
                        next_r.ovf = (r.ovf & ~vcrt_pkg::OVF_UNPROT_MASK)
                            | (io_wdata & vcrt_pkg::OVF_UNPROT_MASK);
                    else
                        next_r.ovf = io_wdata;
                end
                vcrt_pkg::IDX_PRESET_ROW: next_r.prs = io_wdata & vcrt_pkg::PRESET_RD_MASK;
                vcrt_pkg::IDX_MAX_SCAN: next_r.msl = io_wdata;
                vcrt_pkg::IDX_START_HI: next_r.sah = io_wdata;
                vcrt_pkg::IDX_START_LO: next_r.sal = io_wdata;
                vcrt_pkg::IDX_VSYNC_START: next_r.vss = io_wdata;
                vcrt_pkg::IDX_VSYNC_END: next_r.vse = io_wdata;
                vcrt_pkg::IDX_VDISP_END: next_r.vde = io_wdata;
                vcrt_pkg::IDX_VBLANK_START: next_r.vbs = io_wdata;
                vcrt_pkg::IDX_LINE_COMPARE: next_r.lc = io_wdata;
                default: ;
            endcase
        end
        if (io_rd)
        begin
            next_r.rdata = 8'h00;
            if (io_addr == idx_port)
                next_r.rdata = {1'b0, r.index};
            else if (io_addr == dat_port)
            begin
                unique case (r.index)
                    vcrt_pkg::IDX_HSYNC_START: next_r.rdata = r.hss;
                    vcrt_pkg::IDX_HSYNC_END: next_r.rdata = r.hse;
                    vcrt_pkg::IDX_VERT_TOTAL: next_r.rdata = r.vt;
                    vcrt_pkg::IDX_VERT_OVERFLOW: next_r.rdata = r.ovf;
                    vcrt_pkg::IDX_PRESET_ROW: next_r.rdata = r.prs & vcrt_pkg::PRESET_RD_MASK;
                    vcrt_pkg::IDX_MAX_SCAN: next_r.rdata = r.msl;
                    vcrt_pkg::IDX_START_HI: next_r.rdata = r.sah;
                    vcrt_pkg::IDX_START_LO: next_r.rdata = r.sal;
                    vcrt_pkg::IDX_VSYNC_START: next_r.rdata = r.vss;
                    vcrt_pkg::IDX_VSYNC_END: next_r.rdata = r.vse;
                    vcrt_pkg::IDX_VDISP_END: next_r.rdata = r.vde;
                    vcrt_pkg::IDX_VBLANK_START: next_r.rdata = r.vbs;
                    vcrt_pkg::IDX_LINE_COMPARE: next_r.rdata = r.lc;
                    default: next_r.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.hse <= vcrt_pkg::RST_HSYNC_END;
            r.vt <= vcrt_pkg::RST_VERT_TOTAL;
            r.ovf <= vcrt_pkg::RST_OVERFLOW;
            r.prs <= vcrt_pkg::RST_PRESET;
            r.msl <= vcrt_pkg::RST_MAX_SCAN;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign io_rdata = r.rdata;
    assign hsync_start_reg = r.hss;
    assign hsync_end_reg = r.hse;
    assign vert_total_reg = r.vt;
    assign vert_overflow_reg = r.ovf;
    assign preset_row_scan_reg = r.prs;
    assign max_scan_line_reg = r.msl;
    assign start_addr = {r.sah, r.sal};
    assign vsync_start_reg = r.vss;
    assign vsync_end_protect_reg = r.vse;
    assign vert_disp_end_reg = r.vde;
    assign vert_blank_start_reg = r.vbs;
    assign line_compare_reg = r.lc;

endmodule

`default_nettype wire

// file: hw/vcrt_top.sv
// Vertical timing, overflow assembly, split screen and byte panning of a CRT controller.
// Assumes the horizontal block supplies the character count, char enable and line end.
//
// Notes on behaviour
// - Horizontal retrace drops when count low five match, vertical when line low four match
// - Vertical total built from ten assembled bits
// - Display end built from ten assembled bits
// - Sync start built from ten assembled bits
// - Blank start uses max scan bit nine
// - Address counter restarts at line compare
// - Lines after split fetch from byte zero
// - First active line is numbered zero
// - Protection covers total and most overflow
// - Byte pan shifts by eight or nine
// - Nine dot disable forces eight pixel shift
// - Panning applies in text and graphics
// - Preset row bit seven reads zero
// - Protect bit blocks protected timing writes
// - Index port selects data port register
// - Top row starts at preset scan line
`timescale 1ns/100ps
`default_nettype none

module vcrt_top
(
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic color_emul, // Colour emulation address select
    input wire logic [15:0] io_addr, // I/O address
    input wire logic io_wr, // I/O write strobe
    input wire logic io_rd, // I/O read strobe
    input wire logic [7:0] io_wdata, // I/O write data
    output logic [7:0] io_rdata, // I/O read data
    input wire logic char_en, // Character clock enable pulse
    input wire logic [7:0] h_count, // Horizontal character count
    input wire logic line_end, // Last character of a line, pulse
    input wire logic text_mode, // Text mode selected
    input wire logic nine_dot, // Nine pixel character box
    input wire logic nine_dot_disable, // Nine dot disable control
    output logic hretrace, // Horizontal retrace
    output logic vretrace, // Vertical retrace
    output logic vdisp_en, // Vertical display enable
    output logic vblank, // Vertical blanking
    output logic [9:0] scan_line, // Current scan line
    output logic [4:0] row_scan, // Row scan within character box
    output logic [15:0] row_start_addr, // Memory address counter start
    output logic addr_restart, // Address counter restarted, pulse
    output logic split_active, // Lower split screen part
    output logic [4:0] pan_pixels // Byte panning shift in pixels
);

    typedef struct packed
    {
        logic [9:0] line;
        logic [4:0] row;
        logic dbl_phase;
        logic hret;
        logic vret;
        logic vde;
        logic vbl;
        logic [15:0] base;
        logic restart;
        logic split;
        logic [4:0] pan;
    } vcrt_state_type;

    vcrt_state_type s;
    vcrt_state_type next_s;

    logic [7:0] hss;
    logic [7:0] hse;
    logic [7:0] vt_lo;
    logic [7:0] ovf;
    logic [7:0] prs;
    logic [7:0] msl;
    logic [15:0] start_addr;
    logic [7:0] vss_lo;
    logic [7:0] vse;
    logic [7:0] vde_lo;
    logic [7:0] vbs_lo;
    logic [7:0] lc_lo;
    logic [9:0] vert_total;
    logic [9:0] vert_disp_end;
    logic [9:0] vsync_start;
    logic [9:0] vblank_start;
    logic [9:0] line_compare;
    logic [9:0] line_next;
    logic wrap;
    logic row_step;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    vcrt_regs u_regs
    (
        .clk(clk),
        .rst_n(rst_n),
        .color_emul(color_emul),
        .io_addr(io_addr),
        .io_wr(io_wr),
        .io_rd(io_rd),
        .io_wdata(io_wdata),
        .io_rdata(io_rdata),
        .hsync_start_reg(hss),
        .hsync_end_reg(hse),
        .vert_total_reg(vt_lo),
        .vert_overflow_reg(ovf),
        .preset_row_scan_reg(prs),
        .max_scan_line_reg(msl),
        .start_addr(start_addr),
        .vsync_start_reg(vss_lo),
        .vsync_end_protect_reg(vse),
        .vert_disp_end_reg(vde_lo),
        .vert_blank_start_reg(vbs_lo),
        .line_compare_reg(lc_lo)
    );

    // ----------------------------------------
    // Ten-bit compare values
    // ----------------------------------------
    assign vert_total = {ovf[vcrt_pkg::OVF_VT9], ovf[vcrt_pkg::OVF_VT8], vt_lo};
    assign vert_disp_end = {ovf[vcrt_pkg::OVF_VDE9], ovf[vcrt_pkg::OVF_VDE8], vde_lo};
    assign vsync_start = {ovf[vcrt_pkg::OVF_VSS9], ovf[vcrt_pkg::OVF_VSS8], vss_lo};
    assign vblank_start = {msl[vcrt_pkg::MSL_VBS9], ovf[vcrt_pkg::OVF_VBS8], vbs_lo};
    assign line_compare = {msl[vcrt_pkg::MSL_LC9], ovf[vcrt_pkg::OVF_LC8], lc_lo};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.restart = 1'b0;
        // Frame holds total plus two lines, numbered from zero
        wrap = (s.line == 10'(vert_total + 10'h001));
        line_next = wrap ? 10'h000 : 10'(s.line + 10'h001);
        row_step = !msl[vcrt_pkg::MSL_DBL] || s.dbl_phase;

        if (char_en)
        begin
            // Start wins if both compares hit in one character
            if (h_count == hss)
                next_s.hret = 1'b1;
            else if (h_count[4:0] == hse[4:0])
                next_s.hret = 1'b0;
        end

        if (line_end)
        begin
            next_s.line = line_next;
            if (wrap)
            begin
                next_s.row = prs[4:0];
                next_s.dbl_phase = 1'b0;
                next_s.base = start_addr;
                next_s.split = 1'b0;
                next_s.restart = 1'b1;
            end
            else
            begin
                next_s.dbl_phase = !s.dbl_phase;
                if (row_step)
                    next_s.row = (s.row == msl[4:0]) ? 5'h00 : 5'(s.row + 5'h01);
            end
            if (line_next == line_compare)
            begin
                next_s.base = 16'h0000;
                next_s.row = 5'h00;
                next_s.dbl_phase = 1'b0;
                next_s.split = 1'b1;
                next_s.restart = 1'b1;
            end
        end

        next_s.vde = (s.line <= vert_disp_end);
        next_s.vbl = (s.line >= vblank_start);
        if (s.line == vsync_start)
            next_s.vret = 1'b1;
        else if (s.line[3:0] == vse[3:0])
            next_s.vret = 1'b0;

        // Nine pixel shift only in text mode with nine dot box and no disable, else eight
        unique case (prs[6:5])
            2'b00: next_s.pan = 5'h00;
            2'b01: next_s.pan = pix_per_byte(nine_dot, nine_dot_disable, text_mode);
            2'b10: next_s.pan = 5'(pix_per_byte(nine_dot, nine_dot_disable, text_mode) << 1);
            2'b11: next_s.pan = 5'(pix_per_byte(nine_dot, nine_dot_disable, text_mode) * 3);
        endcase
    end

    // ----------------------------------------
    // Pixels per panned byte
    // ----------------------------------------
    function automatic logic [4:0] pix_per_byte(input logic nine, input logic disable9,
                                                input logic text);
        if (nine && text && !disable9)
            return vcrt_pkg::PIX_PER_BYTE_9;
        else
            return vcrt_pkg::PIX_PER_BYTE_8;
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign hretrace = s.hret;
    assign vretrace = s.vret;
    assign vdisp_en = s.vde;
    assign vblank = s.vbl;
    assign scan_line = s.line;
    assign row_scan = s.row;
    assign row_start_addr = s.base;
    assign addr_restart = s.restart;
    assign split_active = s.split;
    assign pan_pixels = s.pan;

endmodule

`default_nettype wire

// file: dv/vcrt_top_asserts.sv
// Port-level checks of the vertical timing block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module vcrt_top_asserts
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic io_rd, // Read strobe
    input wire logic [7:0] io_rdata, // Read data
    input wire logic text_mode, // Text mode
    input wire logic nine_dot, // Nine pixel box
    input wire logic nine_dot_disable, // Nine dot disable
    input wire logic vdisp_en, // Display enable
    input wire logic [9:0] scan_line, // Line count
    input wire logic [4:0] row_scan, // Row scan
    input wire logic [15:0] row_start_addr, // Address start
    input wire logic addr_restart, // Restart pulse
    input wire logic split_active, // Lower split part
    input wire logic [4:0] pan_pixels // Pan shift
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_frame_top;
        addr_restart && !split_active;
    endsequence
    sequence s_split_top;
        addr_restart && split_active;
    endsequence

    a_pan_nine_steps:
        assert property ((text_mode && nine_dot && !nine_dot_disable) [*2]
            |-> pan_pixels inside {5'h00, 5'h09, 5'h12, 5'h1b})
        else $error("pan not a nine pixel step");
    a_pan_eight_steps:
        assert property ((!text_mode || !nine_dot || nine_dot_disable) [*2]
            |-> pan_pixels inside {5'h00, 5'h08, 5'h10, 5'h18})
        else $error("pan not an eight pixel step");
    a_pan_graphics_mode:
        assert property (!text_mode [*2] |-> pan_pixels[2:0] == 3'h0)
        else $error("graphics pan wrong");
    a_split_base_zero:
        assert property (s_split_top |-> row_start_addr == 16'h0000 && row_scan == 5'h00)
        else $error("split restart not at zero");
    a_wrap_line_zero:
        assert property (s_frame_top |-> scan_line == 10'h000)
        else $error("frame restart off line zero");
    a_split_ends_wrap:
        assert property ($fell(split_active) |-> s_frame_top)
        else $error("split ended outside wrap");
    a_line_steps_one:
        assert property ($changed(scan_line)
            |-> scan_line == $past(scan_line) + 10'h001 || scan_line == 10'h000)
        else $error("line count jumped");
    a_wrap_restarts:
        assert property ($changed(scan_line) && scan_line == 10'h000 |-> addr_restart)
        else $error("wrap without restart");
    a_top_displayed:
        assert property (s_frame_top |=> vdisp_en)
        else $error("line zero not displayed");
    a_rdata_stands:
        assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without read");
    a_restart_pulse:
        assert property (addr_restart |=> !addr_restart)
        else $error("restart longer than a cycle");
endmodule

bind vcrt_top vcrt_top_asserts u_asserts (.clk(clk), .rst_n(rst_n), .io_rd(io_rd),
    .io_rdata(io_rdata), .text_mode(text_mode), .nine_dot(nine_dot),
    .nine_dot_disable(nine_dot_disable), .vdisp_en(vdisp_en), .scan_line(scan_line),
    .row_scan(row_scan), .row_start_addr(row_start_addr), .addr_restart(addr_restart),
    .split_active(split_active), .pan_pixels(pan_pixels));

`default_nettype wire

// file: dv/vcrt_horiz_model.sv
// Horizontal source and sync receiver facing the vertical block.
// Assumes eight characters a line, one character each clock.
`timescale 1ns/100ps
`default_nettype none

module vcrt_horiz_model
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic hretrace, // Retrace from block
    output logic char_en, // Character enable
    output logic [7:0] h_count, // Character count
    output logic line_end, // Last character
    output logic [7:0] hret_width // Retrace cycles of last line
);
    logic [7:0] width_cnt;

    assign char_en = rst_n;
    assign line_end = char_en && h_count == 8'h07;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            h_count <= 8'h00;
            width_cnt <= 8'h00;
            hret_width <= 8'h00;
        end
        else
        begin
            h_count <= line_end ? 8'h00 : h_count + 8'h01;
            width_cnt <= line_end ? 8'h00 : width_cnt + {7'h00, hretrace};
            if (line_end)
            begin
                hret_width <= width_cnt + {7'h00, hretrace};
            end
        end
    end
endmodule

`default_nettype wire

// file: dv/vga_crtc_vertical_overflow_timing_bench.sv
// Self-checking bench of the vertical timing block.
// Assumes the horizontal model drives the character timing.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) \
        begin \
            n_errors++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module vga_crtc_vertical_overflow_timing_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic color_emul = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic text_mode = 1'b1;
    logic nine_dot = 1'b1;
    logic nine_dot_disable = 1'b0;
    logic [7:0] io_rdata, h_count, hret_width;
    logic char_en, line_end, hretrace, vretrace, vdisp_en, vblank, addr_restart, split_active;
    logic [9:0] scan_line;
    logic [4:0] row_scan, pan_pixels;
    logic [15:0] row_start_addr;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [6:0] s_idx [13] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h12, 7'h10, 7'h15,
        7'h09, 7'h18, 7'h11, 7'h0c, 7'h0d, 7'h08};
    logic [7:0] s_dat [13] = '{8'h02, 8'h05, 8'h01, 8'h7d, 8'he0, 8'hf0, 8'h00,
        8'h23, 8'h20, 8'h05, 8'h12, 8'h34, 8'h02};

    always #2.5 clk = ~clk;

    vcrt_top dut (.clk(clk), .rst_n(rst_n), .color_emul(color_emul), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .char_en(char_en), .h_count(h_count), .line_end(line_end), .text_mode(text_mode),
        .nine_dot(nine_dot), .nine_dot_disable(nine_dot_disable), .hretrace(hretrace),
        .vretrace(vretrace), .vdisp_en(vdisp_en), .vblank(vblank), .scan_line(scan_line),
        .row_scan(row_scan), .row_start_addr(row_start_addr), .addr_restart(addr_restart),
        .split_active(split_active), .pan_pixels(pan_pixels));

    vcrt_horiz_model u_horiz (.clk(clk), .rst_n(rst_n), .hretrace(hretrace),
        .char_en(char_en), .h_count(h_count), .line_end(line_end), .hret_width(hret_width));

    // ----------------------------------------
    // Bus and helper tasks
    // ----------------------------------------
    function automatic logic [15:0] port(input logic dat);
        if (color_emul)
            return dat ? vcrt_pkg::DAT_PORT_COLOR : vcrt_pkg::IDX_PORT_COLOR;
        return dat ? vcrt_pkg::DAT_PORT_MONO : vcrt_pkg::IDX_PORT_MONO;
    endfunction

    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
    endtask

    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1;
        io_rd = 1'b0;
        d = io_rdata;
    endtask

    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d);
        io_write(port(1'b0), {1'b0, idx});
        io_write(port(1'b1), d);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] ex);
        logic [7:0] v;
        io_write(port(1'b0), {1'b0, idx});
        io_read(port(1'b1), v);
        `CHK("register", ex, v)
    endtask

    task automatic do_reset;
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask

    task automatic finish_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_byte_pan;
        logic [4:0] ex;
        for (int m = 0; m < 4; m++)
        begin
            text_mode = (m != 2);
            nine_dot = (m != 1);
            nine_dot_disable = (m == 3);
            for (int bp = 0; bp < 4; bp++)
            begin
                ex = 5'(bp * ((m == 0) ? 9 : 8));
                wr_reg(7'h08, {1'b0, 2'(bp), 5'h02});
                repeat (2) @(posedge clk);
                #1;
                `CHK("pan", ex, pan_pixels)
            end
        end
    endtask

    task automatic wait_top;
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (!(addr_restart && !split_active) && n < 20000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20000)
            n_errors++;
    endtask

    task automatic t_frame;
        logic [9:0] mx, vde_f, vb_r, vr_r, vr_f, sp_l;
        logic [15:0] sp_a;
        logic [4:0] sp_r;
        logic pv, pb, pr, ps;
        for (int i = 0; i < 13; i++)
            wr_reg(s_idx[i], s_dat[i]);
        wait_top();
        wait_top();
        `CHK("top base", 16'h1234, row_start_addr)
        `CHK("top row", 5'h02, row_scan)
        mx = 10'h000;
        pv = vdisp_en;
        pb = vblank;
        pr = vretrace;
        ps = split_active;
        do
        begin
            @(posedge clk);
            #1;
            if (scan_line > mx)
                mx = scan_line;
            if (pv && !vdisp_en)
                vde_f = scan_line;
            if (!pb && vblank)
                vb_r = scan_line;
            if (!pr && vretrace)
                vr_r = scan_line;
            if (pr && !vretrace)
                vr_f = scan_line;
            if (!ps && split_active)
            begin
                sp_l = scan_line;
                sp_a = row_start_addr;
                sp_r = row_scan;
            end
            pv = vdisp_en;
            pb = vblank;
            pr = vretrace;
            ps = split_active;
        end while (!(addr_restart && !split_active));
        `CHK("last line", 10'h302, mx)
        `CHK("display end", 10'h2e1, vde_f)
        `CHK("blank start", 10'h300, vb_r)
        `CHK("sync start", 10'h1f0, vr_r)
        `CHK("sync end", 10'h1f5, vr_f)
        `CHK("split line", 10'h120, sp_l)
        `CHK("split base", 16'h0000, sp_a)
        `CHK("split row", 5'h00, sp_r)
        `CHK("retrace width", 8'h03, hret_width)
        wr_reg(7'h09, 8'ha3);
        wait_top();
        repeat (8) @(posedge clk);
        #1;
        `CHK("double scan row", 5'h02, row_scan)
    endtask

    task automatic t_protect_and_ports;
        logic [7:0] v;
        wr_reg(7'h11, 8'h85);
        wr_reg(7'h06, 8'haa);
        wr_reg(7'h07, 8'h00);
        wr_reg(7'h05, 8'h1f);
        rd_chk(7'h06, 8'h01);
        rd_chk(7'h07, 8'h6d);
        rd_chk(7'h05, 8'h05);
        @(posedge clk);
        #1;
        color_emul = 1'b0;
        rd_chk(7'h06, 8'h01);
        io_write(vcrt_pkg::IDX_PORT_COLOR, 8'h08);
        io_write(vcrt_pkg::DAT_PORT_COLOR, 8'h7f);
        rd_chk(7'h08, 8'h02);
        io_read(vcrt_pkg::DAT_PORT_COLOR, v);
        `CHK("foreign port", 8'h00, v)
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_chk(7'h05, 8'h00);
        rd_chk(7'h06, 8'h00);
        rd_chk(7'h07, 8'h00);
        rd_chk(7'h30, 8'h00);
        wr_reg(7'h08, 8'hff);
        rd_chk(7'h08, 8'h7f);
        t_byte_pan();
        t_frame();
        t_protect_and_ports();
        do_reset();
        rd_chk(7'h06, 8'h00);
        finish_test();
    end
endmodule

`default_nettype wire
